/* design/viu_top.sv */
// Vectored interrupt unit with AHB-Lite register slave
//
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/10ps
`include "viu_cfg.svh"
module viu_top #(
  parameter int FILT_CYCLES = `VIU_FILT_CYCLES
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [`VIU_NUM_EXT-1:0] ext_int_pin,
  input wire logic [`VIU_NUM_PERIPH-1:0] periph_event,
  input wire logic enable_interrupts_instr,
  input wire logic disable_interrupts_instr,
  input wire logic return_from_interrupt_instr,
  input wire logic int_ack,
  input wire viu_pkg::viu_ctx_t core_ctx,
  output logic int_req,
  output logic [7:0] int_vector,
  output logic restore_valid,
  output viu_pkg::viu_ctx_t restore_ctx
);
  localparam int NS = `VIU_NUM_SRC;
  localparam logic [2:0] FILT_LAST = 3'(FILT_CYCLES - 1);
  localparam logic [NS*8-1:0] VEC_TAB = `VIU_VEC_TABLE;
  localparam logic [NS*5-1:0] PRI_TAB = `VIU_PRI_TABLE;

  logic [1:0] rst_sync_q;
  logic rst_n;
  logic [`VIU_NUM_EXT-1:0] ext_s1_q, ext_s2_q, ext_s3_q, ext_filt_q, ext_prev_q, ext_fall;
  logic [2:0] ext_cnt_q [`VIU_NUM_EXT];
  logic [NS-1:0] src_evt, set_gate, elig, flag_q, flag_d, mask_q, mask_d;
  logic gie_q, vde_q, vde_d, active_q, take;
  logic dph_wr_q;
  logic [7:0] dph_idx_q;
  logic [31:0] hrdata_q;
  logic ap_ok;
  viu_pkg::viu_sel_t sel_q, sel_d;
  viu_pkg::viu_ctx_t saved_q;
  logic restore_valid_q;

  // Address falls in a four-word register group
  function automatic logic grp_hit(input logic [7:0] idx, input logic [7:0] base);
    return (idx >= base) && (idx < base + `VIU_GRP_LEN);
  endfunction

  // Byte lane of a group member within a 32-bit vector
  function automatic logic [4:0] grp_lsb(input logic [7:0] idx, input logic [7:0] base);
    logic [7:0] off;
    off = idx - base;
    return {off[1:0], 3'b000};
  endfunction

  // Reset release through two flops
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // Pin synchronisers, three stages
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_s1_q <= '1;
      ext_s2_q <= '1;
      ext_s3_q <= '1;
    end else begin
      ext_s1_q <= ext_int_pin;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end

  // Noise filter: new level must hold four clocks
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_filt_q <= '1;
      ext_prev_q <= '1;
      for (int i = 0; i < `VIU_NUM_EXT; i++) begin
        ext_cnt_q[i] <= 3'h0;
      end
    end else begin
      ext_prev_q <= ext_filt_q;
      for (int i = 0; i < `VIU_NUM_EXT; i++) begin
        if ((ext_s2_q[i] == ext_s3_q[i]) && (ext_s3_q[i] != ext_filt_q[i])) begin
          if (ext_cnt_q[i] == FILT_LAST) begin
            ext_filt_q[i] <= ext_s3_q[i];
            ext_cnt_q[i] <= 3'h0;
          end else begin
            ext_cnt_q[i] <= ext_cnt_q[i] + 3'h1;
          end
        end else begin
          ext_cnt_q[i] <= 3'h0;
        end
      end
    end
  end

  // Falling edge of filtered level is the request
  assign ext_fall = ext_prev_q & ~ext_filt_q;
  assign src_evt = {periph_event, ext_fall};

  // Set gating and eligibility per source
  always_comb begin
    for (int i = 0; i < NS; i++) begin
      set_gate[i] = 1'b1;
      if (i >= `VIU_SRC_PC_LO && i <= `VIU_SRC_PC_HI) begin
        set_gate[i] = mask_q[i];
      end
      elig[i] = flag_q[i] & mask_q[i] & gie_q;
      if (i == `VIU_SRC_MTB_PER) begin
        elig[i] = flag_q[i] & mask_q[i];
      end
      if (i == `VIU_SRC_LVD) begin
        elig[i] = flag_q[i] & mask_q[i] & gie_q & vde_q;
      end
    end
  end

  // Register writes; a same-cycle event beats the clear
  always_comb begin
    logic [31:0] f32;
    logic [31:0] m32;
    f32 = {1'b0, flag_q};
    m32 = {1'b0, mask_q};
    vde_d = vde_q;
    if (dph_wr_q) begin
      if (grp_hit(dph_idx_q, `VIU_IDX_STAT)) begin
        f32[grp_lsb(dph_idx_q, `VIU_IDX_STAT) +: 8] = hwdata[7:0];
      end else if (grp_hit(dph_idx_q, `VIU_IDX_MASK)) begin
        m32[grp_lsb(dph_idx_q, `VIU_IDX_MASK) +: 8] = hwdata[7:0];
      end else if (dph_idx_q == `VIU_IDX_CTRL) begin
        vde_d = hwdata[`VIU_CTRL_VDE];
      end
    end
    flag_d = f32[NS-1:0] | (src_evt & set_gate);
    mask_d = m32[NS-1:0];
  end

  // Flag, mask and detector enable storage
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= `VIU_FLAG_RST;
      mask_q <= `VIU_MASK_RST;
      vde_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
      mask_q <= mask_d;
      vde_q <= vde_d;
    end
  end

  // Pick the smallest priority value, lowest index on a tie
  always_comb begin
    logic [4:0] best_pri;
    best_pri = 5'h1f;
    sel_d = '0;
    for (int i = 0; i < NS; i++) begin
      if (elig[i] && (!sel_d.req || PRI_TAB[i*5 +: 5] < best_pri)) begin
        best_pri = PRI_TAB[i*5 +: 5];
        sel_d.req = 1'b1;
        sel_d.src = 5'(i);
        sel_d.vec = VEC_TAB[i*8 +: 8];
      end
    end
  end

  assign take = int_ack & sel_q.req;

  // Registered request; dropped on the acknowledge
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_q <= '0;
    end else if (take) begin
      sel_q <= '0;
    end else begin
      sel_q <= sel_d;
    end
  end
  assign int_req = sel_q.req;
  assign int_vector = sel_q.vec;

  // Global enable
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      gie_q <= 1'b0;
    end else if (take || disable_interrupts_instr) begin
      gie_q <= 1'b0;
    end else if (enable_interrupts_instr || return_from_interrupt_instr) begin
      gie_q <= 1'b1;
    end
  end

  // Context save on entry, restore on return
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      saved_q <= '0;
      active_q <= 1'b0;
      restore_valid_q <= 1'b0;
    end else begin
      if (take) begin
        saved_q <= core_ctx;
        active_q <= 1'b1;
      end else if (return_from_interrupt_instr) begin
        active_q <= 1'b0;
      end
      restore_valid_q <= return_from_interrupt_instr;
    end
  end
  assign restore_valid = restore_valid_q;
  assign restore_ctx = saved_q;

  // Bus address phase accepted
  assign ap_ok = hsel & htrans[1] & hready & (hsize == `VIU_HSIZE_WORD) &
                 (haddr[31:10] == 22'h0) & (haddr[1:0] == 2'b00);

  // Data phase capture and read data, zero wait states
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dph_wr_q <= 1'b0;
      dph_idx_q <= 8'h00;
      hrdata_q <= 32'h0;
    end else begin
      dph_wr_q <= ap_ok & hwrite;
      dph_idx_q <= haddr[9:2];
      if (ap_ok && !hwrite) begin
        if (grp_hit(haddr[9:2], `VIU_IDX_STAT)) begin
          hrdata_q <= {24'h0, 8'({1'b0, flag_d} >> grp_lsb(haddr[9:2], `VIU_IDX_STAT))};
        end else if (grp_hit(haddr[9:2], `VIU_IDX_MASK)) begin
          hrdata_q <= {24'h0, 8'({1'b0, mask_d} >> grp_lsb(haddr[9:2], `VIU_IDX_MASK))};
        end else if (haddr[9:2] == `VIU_IDX_CTRL) begin
          hrdata_q <= {29'h0, active_q, gie_q, vde_d};
        end else if (haddr[9:2] == `VIU_IDX_PEND) begin
          hrdata_q <= {24'h0, sel_q.req, sel_q.vec[6:0]};
        end else begin
          hrdata_q <= 32'h0;
        end
      end
    end
  end
  assign hrdata = hrdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // Return: enable back on, restore strobe for one cycle
  sequence restore_pulse;
    gie_q && restore_valid ##1 !restore_valid;
  endsequence

  // State right after an acknowledged request
  sequence entry_state;
    !int_req && !gie_q && active_q;
  endsequence

  gie_on_enable_a: assert property (enable_interrupts_instr && !take && !disable_interrupts_instr |=> gie_q)
    else $error("enable instruction did not set global enable");
  gie_off_disable_a: assert property (disable_interrupts_instr |=> !gie_q)
    else $error("disable instruction did not clear global enable");
  return_from_interrupt_instr_enables_a: assert property (return_from_interrupt_instr && !take && !disable_interrupts_instr
    |=> restore_pulse)
    else $error("return did not re-enable and pulse restore");
  flag_sticky_a: assert property (periph_event[`VIU_SRC_TM1-2] && !dph_wr_q |=> flag_q[`VIU_SRC_TM1] [*2])
    else $error("timer flag not set or not held");
  pin_change_gate_a: assert property (!flag_q[`VIU_SRC_PC_LO] && !mask_q[`VIU_SRC_PC_LO] && !dph_wr_q
    |=> !flag_q[`VIU_SRC_PC_LO])
    else $error("pin change flag set while disabled");
  ctx_save_a: assert property (take |=> restore_ctx == $past(core_ctx) && !int_req)
    else $error("context not saved on entry");
  filter_width_a: assert property ($fell(ext_filt_q[`VIU_SRC_EXT1]) |->
    $past(!ext_s3_q[`VIU_SRC_EXT1], 1) && $past(!ext_s3_q[`VIU_SRC_EXT1], 2) &&
    $past(!ext_s3_q[`VIU_SRC_EXT1], 3) && $past(!ext_s3_q[`VIU_SRC_EXT1], 4))
    else $error("external level changed before four clocks");
  ext_vector_a: assert property (elig == (31'h1 << `VIU_SRC_EXT1) && !take
    |=> int_req && int_vector == `VIU_VEC_EXT1)
    else $error("external request not vectored to two");
  top_priority_a: assert property (elig[`VIU_SRC_MTA_PER] && !take
    |=> int_vector == `VIU_VEC_MTA_PER)
    else $error("highest priority source not chosen");

  // Entry and return bookkeeping
  entry_state_a: assert property (take |=> entry_state)
    else $error("acknowledge did not enter service");
  return_from_interrupt_instr_inactive_a: assert property (return_from_interrupt_instr && !take |=> !active_q)
    else $error("return did not leave service");
  restore_holds_a: assert property (!take |=> $stable(restore_ctx))
    else $error("saved context changed without acknowledge");
  restore_cause_a: assert property (restore_valid |-> $past(return_from_interrupt_instr))
    else $error("restore strobe without return");
  gie_hold_a: assert property (!take && !disable_interrupts_instr && !enable_interrupts_instr &&
    !return_from_interrupt_instr |=> $stable(gie_q))
    else $error("global enable changed without cause");

  // Request gating
  req_needs_flag_a: assert property (int_req |-> $past(|(flag_q & mask_q)))
    else $error("request without enabled flag");
  no_req_gie_off_a: assert property (!gie_q && !(flag_q[`VIU_SRC_MTB_PER] && mask_q[`VIU_SRC_MTB_PER])
    |=> !int_req)
    else $error("request raised while globally disabled");
  mtb_no_gie_a: assert property (flag_q[`VIU_SRC_MTB_PER] && mask_q[`VIU_SRC_MTB_PER] && !take
    |=> int_req)
    else $error("motor timer B request blocked");
  lvd_needs_det_a: assert property (!vde_q && !take |=> !(int_req && sel_q.src == `VIU_SRC_LVD))
    else $error("voltage detect served without detector enable");

  // Flag and mask storage
  mask_hold_a: assert property (!dph_wr_q |=> $stable(mask_q))
    else $error("mask changed without write");
  flag_hold_a: assert property (!dph_wr_q && !(|src_evt) |=> $stable(flag_q))
    else $error("flag changed without event or write");
  event_sets_a: assert property (!dph_wr_q |=>
    (flag_q & $past(src_evt & set_gate)) == $past(src_evt & set_gate))
    else $error("event did not set its flag");
  set_wins_a: assert property (dph_wr_q && src_evt[`VIU_SRC_TM1] |=> flag_q[`VIU_SRC_TM1])
    else $error("clear beat a same cycle event");
  write_stat_a: assert property (dph_wr_q && dph_idx_q == `VIU_IDX_STAT && src_evt[7:0] == 8'h00
    |=> flag_q[7:0] == $past(hwdata[7:0]))
    else $error("status write not stored");
  write_mask_a: assert property (dph_wr_q && dph_idx_q == `VIU_IDX_MASK
    |=> mask_q[7:0] == $past(hwdata[7:0]))
    else $error("mask write not stored");
  vde_write_a: assert property (dph_wr_q && dph_idx_q == `VIU_IDX_CTRL
    |=> vde_q == $past(hwdata[`VIU_CTRL_VDE]))
    else $error("detector enable write not stored");
  read_high_a: assert property (hrdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");

  // External pins
  filter_rise_a: assert property ($rose(ext_filt_q[`VIU_SRC_EXT1]) |->
    $past(ext_s3_q[`VIU_SRC_EXT1], 1) && $past(ext_s3_q[`VIU_SRC_EXT1], 2) &&
    $past(ext_s3_q[`VIU_SRC_EXT1], 3) && $past(ext_s3_q[`VIU_SRC_EXT1], 4))
    else $error("external level rose before four clocks");
  filter_ext0_a: assert property ($fell(ext_filt_q[0]) |->
    $past(!ext_s3_q[0], 1) && $past(!ext_s3_q[0], 2) && $past(!ext_s3_q[0], 3) && $past(!ext_s3_q[0], 4))
    else $error("external zero changed before four clocks");
  ext_fall_sets_a: assert property (ext_fall[`VIU_SRC_EXT1] && !dph_wr_q |=> flag_q[`VIU_SRC_EXT1])
    else $error("falling edge did not set flag");

  // Vectors and priority
  pc_vector_a: assert property (elig == (31'h1 << `VIU_SRC_PC_LO) && !take
    |=> int_req && int_vector == `VIU_VEC_PC)
    else $error("pin change vector wrong");
  lvd_vector_a: assert property (elig == (31'h1 << `VIU_SRC_LVD) && !take
    |=> int_req && int_vector == `VIU_VEC_LVD)
    else $error("voltage detect vector wrong");
  adc_vector_a: assert property (elig == (31'h1 << `VIU_SRC_ADC) && !take
    |=> int_req && int_vector == `VIU_VEC_ADC)
    else $error("converter vector wrong");
  osh_vector_a: assert property (elig == (31'h1 << `VIU_SRC_OSH) && !take
    |=> int_req && int_vector == `VIU_VEC_OSH)
    else $error("one-shot vector wrong");
  mtb_vector_a: assert property (elig == (31'h1 << `VIU_SRC_MTB_PER) && !take
    |=> int_req && int_vector == `VIU_VEC_MTB_PER)
    else $error("motor timer B vector wrong");
  tm1_vector_a: assert property (elig == (31'h1 << `VIU_SRC_TM1) && !take
    |=> int_req && int_vector == `VIU_VEC_TM1)
    else $error("timer one vector wrong");
  adc_over_cmp_a: assert property (elig == ((31'h1 << `VIU_SRC_ADC) | (31'h1 << `VIU_SRC_CMP1)) && !take
    |=> int_vector == `VIU_VEC_ADC)
    else $error("priority order between converter and comparator wrong");
endmodule

/* design/viu_cfg.svh */
// Constants for the vectored interrupt unit
// Notes on behaviour
// - Thirty-one request sources, seven from pins or comparators, twenty-four internal.
// - Each request latches a flag in status registers, apart from the mask registers.
// - Each flagged source has its own enable bit in the mask registers.
// - Enable-interrupts instruction sets the global enable; disable-interrupts clears it.
// - A taken interrupt fetches next from that source's own vector address.
// - Flags set on their event regardless of mask and global enable, except pin-change.
// - Return-from-interrupt ends the routine and sets the global enable.
// - External inputs drop any pulse shorter than four system clocks.
// - External request triggers on a falling edge and vectors to address two.
// - On entry hardware saves accumulator, first, third register bits 0-6, fourth register.
// - A later interrupt overwrites the single saved context.
// - On return hardware restores accumulator, first, third bits 0-6, fourth register.
// - Three pin-change sources share vector 4, priority 28, own enables and flags.
// - Voltage detect needs detector enable and its own enable; vector 8, priority 29.
// - Motor timer A period match: vector 0x42, priority 1, own and global enable.
// - Motor timer A one-shot and six compares: vectors 0x44-0x50, priorities 2-8.
// - Motor timer B period match: vector 0x56, priority 13, own enable only.
// - General timers one to four: vectors 0x5c-0x62, priorities 26,25,24,23.
// - Converter done vector 0x10 priority 12; comparators 0x0a/0x0e, priorities 17/18.
`ifndef VIU_CFG_SVH
`define VIU_CFG_SVH
`define VIU_NUM_SRC 31
`define VIU_NUM_PERIPH 29
`define VIU_NUM_EXT 2
`define VIU_FILT_CYCLES 4
`define VIU_HSIZE_WORD 3'b010
`define VIU_IDX_STAT 8'h14
`define VIU_IDX_MASK 8'h1b
`define VIU_IDX_CTRL 8'h20
`define VIU_IDX_PEND 8'h21
`define VIU_GRP_LEN 8'h04
`define VIU_SRC_EXT1 1
`define VIU_SRC_PC_LO 2
`define VIU_SRC_PC_HI 4
`define VIU_SRC_LVD 5
`define VIU_SRC_MTA_PER 13
`define VIU_SRC_MTB_PER 23
`define VIU_SRC_TM1 26
`define VIU_CTRL_VDE 0
`define VIU_CTRL_GIE 1
`define VIU_CTRL_ACT 2
`define VIU_FLAG_RST 31'h0
`define VIU_MASK_RST 31'h0
`define VIU_VEC_EXT1 8'h02
`define VIU_VEC_MTA_PER 8'h42
`define VIU_SRC_CMP1 6
`define VIU_SRC_ADC 8
`define VIU_SRC_OSH 14
`define VIU_VEC_PC 8'h04
`define VIU_VEC_LVD 8'h08
`define VIU_VEC_ADC 8'h10
`define VIU_VEC_OSH 8'h44
`define VIU_VEC_MTB_PER 8'h56
`define VIU_VEC_TM1 8'h5c
// Vector per source, source 30 leftmost
`define VIU_VEC_TABLE {8'h64, 8'h62, 8'h60, 8'h5e, 8'h5c, 8'h5a, 8'h58, 8'h56, 8'h54, 8'h52, 8'h50, \
  8'h4e, 8'h4c, 8'h4a, 8'h48, 8'h46, 8'h44, 8'h42, 8'h40, 8'h3e, 8'h3c, 8'h3a, 8'h10, 8'h0e, 8'h0a, \
  8'h08, 8'h04, 8'h04, 8'h04, 8'h02, 8'h00}
// Priority per source, smaller wins, source 30 leftmost
`define VIU_PRI_TABLE {5'h1e, 5'h17, 5'h18, 5'h19, 5'h1a, 5'h0f, 5'h0e, 5'h0d, 5'h0a, 5'h09, 5'h08, \
  5'h07, 5'h06, 5'h05, 5'h04, 5'h03, 5'h02, 5'h01, 5'h0b, 5'h10, 5'h16, 5'h15, 5'h0c, 5'h12, 5'h11, \
  5'h1d, 5'h1c, 5'h1c, 5'h1c, 5'h1b, 5'h07}
`endif

/* design/viu_pkg.sv */
// Types shared by the vectored interrupt unit
package viu_pkg;
  // Core context saved on entry and restored on return
  typedef struct packed {
    logic [7:0] r4;
    logic [6:0] r3;
    logic [7:0] r1;
    logic [7:0] accumulator;
  } viu_ctx_t;
  // Selected request presented to the core
  typedef struct packed {
    logic req;
    logic [4:0] src;
    logic [7:0] vec;
  } viu_sel_t;
endpackage

/* bench/viu_core_model.sv */
// Core model: acknowledges requests and presents live context
`timescale 1ns/10ps
module viu_core_model (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic int_req,
  input wire logic [3:0] ack_gap,
  output logic int_ack,
  output viu_pkg::viu_ctx_t core_ctx,
  output viu_pkg::viu_ctx_t saved_ctx
);
  logic [3:0] wait_q;
  // Ack after ack_gap cycles of request; context moves every cycle
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      int_ack <= 1'b0;
      wait_q <= 4'h0;
      core_ctx <= 31'h0;
      saved_ctx <= 31'h0;
    end else begin
      int_ack <= 1'b0;
      core_ctx <= core_ctx + 31'h0a3c5a7;
      if (int_req && !int_ack) begin
        wait_q <= (wait_q >= ack_gap) ? 4'h0 : wait_q + 4'h1;
        int_ack <= (wait_q >= ack_gap);
      end else begin
        wait_q <= 4'h0;
      end
      if (int_ack && int_req) begin
        saved_ctx <= core_ctx;
      end
    end
  end
endmodule

/* bench/tb_top.sv */
// Self-checking bench for the vectored interrupt unit
`timescale 1ns/10ps
module tb_top;
  logic sys_clk, resetn, hsel, hwrite, hreadyout, hresp, int_req, int_ack, restore_valid;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, ext_pin;
  logic [2:0] hsize, ins;
  logic [28:0] ev;
  logic [7:0] int_vector;
  logic [3:0] gap;
  viu_pkg::viu_ctx_t core_ctx, restore_ctx, saved_ctx;
  int error_cnt, total_checks;
  viu_top dut_u (.sys_clk(sys_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .ext_int_pin(ext_pin), .periph_event(ev), .enable_interrupts_instr(ins[0]), .disable_interrupts_instr(ins[1]),
    .return_from_interrupt_instr(ins[2]), .int_ack(int_ack), .core_ctx(core_ctx), .int_req(int_req),
    .int_vector(int_vector), .restore_valid(restore_valid), .restore_ctx(restore_ctx));
  viu_core_model core_u (.sys_clk(sys_clk), .resetn(resetn), .int_req(int_req), .ack_gap(gap), .int_ack(int_ack),
    .core_ctx(core_ctx), .saved_ctx(saved_ctx));
  // Clock generation
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // Compare and count
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Single AHB word transfer
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    hsel <= 1'b1; haddr <= a; htrans <= 2'b10; hwrite <= wr;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= wd;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    rd = hrdata;
  endtask
  task automatic rchk(input logic [31:0] a, input logic [7:0] exp);
    bus(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), rd, {24'h0, exp});
  endtask
  // One-cycle instruction and event pulses
  task automatic step(input logic [2:0] i, input logic [28:0] e);
    ins <= i; ev <= e;
    @(posedge sys_clk);
    ins <= 3'b000; ev <= 29'h0;
  endtask
  // Wait for the core to acknowledge, check the vector
  task automatic take(input logic [7:0] exp);
    int n;
    n = 0;
    do @(negedge sys_clk); while (int_ack !== 1'b1 && ++n < 60);
    chk("int_vector", {24'h0, int_vector}, {24'h0, exp});
    chk("int_req", {31'h0, int_req}, 32'h1);
    @(posedge sys_clk);
  endtask
  task automatic ret_chk;
    step(3'b100, 29'h0);
    @(negedge sys_clk);
    chk("restore_valid", {31'h0, restore_valid}, 32'h1);
    chk("restore_ctx", {1'b0, restore_ctx}, {1'b0, saved_ctx});
    @(posedge sys_clk);
  endtask
  task automatic t_regs;
    rchk(32'h50, 8'h00);
    rchk(32'h6c, 8'h00);
    bus(1'b1, 32'h80, 32'h7);
    rchk(32'h80, 8'h01);
    bus(1'b1, 32'h80, 32'h0);
    bus(1'b1, 32'h90, 32'hff);
    rchk(32'h90, 8'h00);
  endtask
  task automatic t_flag;
    step(3'b000, 29'h1000000);
    rchk(32'h5c, 8'h04);
    chk("int_req", {31'h0, int_req}, 32'h0);
    bus(1'b1, 32'h5c, 32'h0);
    rchk(32'h5c, 8'h00);
  endtask
  task automatic t_nest;
    bus(1'b1, 32'h70, 32'h20);
    bus(1'b1, 32'h78, 32'h04);
    step(3'b001, 29'h1000800);
    take(8'h42);
    rchk(32'h80, 8'h04);
    bus(1'b1, 32'h54, 32'h0);
    ret_chk;
    take(8'h5c);
    bus(1'b1, 32'h5c, 32'h0);
    ret_chk;
  endtask
  task automatic t_motor_b;
    step(3'b010, 29'h0);
    bus(1'b1, 32'h74, 32'h80);
    step(3'b000, 29'h200000);
    take(8'h56);
    bus(1'b1, 32'h58, 32'h0);
    ret_chk;
  endtask
  task automatic t_ext;
    gap <= 4'h0;
    bus(1'b1, 32'h6c, 32'h02);
    ext_pin <= 2'b01;
    repeat (3) @(posedge sys_clk);
    ext_pin <= 2'b11;
    repeat (12) @(posedge sys_clk);
    rchk(32'h50, 8'h00);
    ext_pin <= 2'b01;
    take(8'h02);
    ext_pin <= 2'b11;
    rchk(32'h50, 8'h02);
    bus(1'b1, 32'h50, 32'h0);
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    resetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00; hwrite = 1'b0; hsize = 3'b010;
    hwdata = 32'h0; ext_pin = 2'b11; ev = 29'h0; ins = 3'b000; gap = 4'h4;
    error_cnt = 0;
    total_checks = 0;
    repeat (10) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    t_regs;
    t_flag;
    t_nest;
    t_motor_b;
    t_ext;
    complete_run;
  end
  // Watchdog against a hang
  initial begin
    repeat (4000) @(posedge sys_clk);
    error_cnt++;
    complete_run;
  end
endmodule
